// *** rtl/haptic_pkg.sv ***
// Shared constants, timing figures and state encoding for the haptic playback power control
package haptic_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SAMPLE_W = 8;
  localparam int unsigned BUF_DEPTH = 100;
  localparam logic [7:0] ENTRY_REG_ADDR = 8'h0b;
  localparam logic [7:0] DAC_MID = 8'h00;
  localparam logic [7:0] DAC_POS_FS = 8'h7f;
  localparam logic [7:0] DAC_NEG_FS = 8'h80;
  // Playback rate in Hz and the divider that produces it
  localparam int unsigned SAMPLE_HZ = 8000;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
  // Start-up time in ms, rounded up to whole cycles
  localparam int unsigned STARTUP_MS = 2;
  localparam int unsigned WAKE_CYC = (STARTUP_MS * CLK_HZ + 999) / 1000;
  // Empty-buffer timeout in ms before idle or ramp-down
  localparam int unsigned TIMEOUT_MS = 5;
  localparam int unsigned TIMEOUT_CYC = (TIMEOUT_MS * CLK_HZ) / 1000;
  localparam logic STANDBY_PREV_RST = 1'b1;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b000,
    ST_IDLE = 3'b001,
    ST_WAKE = 3'b011,
    ST_PLAY = 3'b010,
    ST_HOLD = 3'b110,
    ST_RAMP = 3'b111
  } pwr_state_t;
endpackage

// *** rtl/haptic_playback_power_control.sv ***
// Power and playback sequencer for the haptic driver digital front end
`timescale 1ns/1ps
module haptic_playback_power_control #(
  parameter int unsigned SAMPLE_CYC = haptic_pkg::SAMPLE_CYC,
  parameter int unsigned WAKE_CYC = haptic_pkg::WAKE_CYC,
  parameter int unsigned TIMEOUT_CYC = haptic_pkg::TIMEOUT_CYC,
  parameter int unsigned BUF_DEPTH = haptic_pkg::BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_valid,
  input wire logic [haptic_pkg::SAMPLE_W-1:0] wr_data,
  input wire logic standby_bit,
  input wire logic force_power_on_bit,
  input wire logic soft_reset_req,
  output logic wr_ack,
  output logic wr_nak,
  output logic wr_dropped,
  output logic boost_en,
  output logic amp_en,
  output logic [haptic_pkg::SAMPLE_W-1:0] dac_code,
  output logic dac_strobe,
  output logic buf_full,
  output logic standby_active,
  output logic ramp_active,
  output logic soft_reset_bit
);
  import haptic_pkg::*;

  localparam logic [31:0] SAMPLE_LOAD = 32'(SAMPLE_CYC - 1);
  localparam logic [31:0] WAKE_LOAD = 32'(WAKE_CYC - 1);
  localparam logic [31:0] TIMEOUT_LOAD = 32'(TIMEOUT_CYC - 1);

  function automatic logic powered(input pwr_state_t s);
    powered = (s == ST_WAKE) || (s == ST_PLAY) || (s == ST_HOLD) || (s == ST_RAMP);
  endfunction

  pwr_state_t st_r;
  pwr_state_t st_nxt;
  logic [31:0] tmr_r;
  logic [31:0] tmr_nxt;
  logic [31:0] smp_cnt_r;
  logic [7:0] dac_r;
  logic standby_prev_r;
  logic soft_reset_bit_r;
  logic wr_ack_r;
  logic wr_nak_r;
  logic wr_dropped_r;
  logic boost_en_r;
  logic amp_en_r;
  logic dac_strobe_r;
  logic buf_full_r;
  logic standby_active_r;
  logic ramp_active_r;
  logic full_w;
  logic empty_w;
  logic [7:0] fifo_dout;

  // Soft reset is applied on the cycle after the request
  wire srst = soft_reset_bit_r;
  wire standby_fall = standby_prev_r & ~standby_bit;
  wire plays = (st_r == ST_PLAY) || (st_r == ST_HOLD);
  wire ticking = plays || (st_r == ST_RAMP);
  wire tick = ticking && (smp_cnt_r == '0);
  wire tmr_done = (tmr_r == '0);
  wire dac_zero = (dac_r == DAC_MID);
  wire force_on = force_power_on_bit & ~standby_bit;
  wire wr_take = wr_valid & ~standby_bit & (st_r != ST_STANDBY) & ~full_w;
  wire wr_refuse = wr_valid & ~wr_take;
  wire push = wr_take & (st_r != ST_RAMP) & ~srst;
  wire drop = wr_take & (st_r == ST_RAMP);
  wire pop = tick & plays & ~empty_w;
  wire ramp_step = tick & (st_r == ST_RAMP) & ~dac_zero;
  // Move one code toward mid-scale, respecting the sign bit
  wire [7:0] dac_step = dac_r[7] ? dac_r + 8'h01 : dac_r - 8'h01;
  wire entering = (st_nxt != st_r);

  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(standby_bit | srst),
    .push(push),
    .din(wr_data),
    .pop(pop),
    .dout(fifo_dout),
    .full(full_w),
    .empty(empty_w)
  );

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_STANDBY: begin
        if (standby_fall) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (push || force_on) begin
          st_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (tmr_done) begin
          st_nxt = ST_PLAY;
        end
      end
      ST_PLAY: begin
        if (tick && empty_w) begin
          st_nxt = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!empty_w) begin
          st_nxt = ST_PLAY;
        end else if (tmr_done && !dac_zero) begin
          st_nxt = ST_RAMP;
        end else if (tmr_done && !force_on) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RAMP: begin
        if (dac_zero) begin
          st_nxt = force_on ? ST_HOLD : ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_STANDBY;
      end
    endcase
    if (standby_bit) begin
      st_nxt = ST_STANDBY;
    end
  end

  always_comb begin
    if (entering && st_nxt == ST_WAKE) begin
      tmr_nxt = WAKE_LOAD;
    end else if (entering && st_nxt == ST_HOLD) begin
      tmr_nxt = TIMEOUT_LOAD;
    end else if (tmr_done) begin
      tmr_nxt = '0;
    end else begin
      tmr_nxt = tmr_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      soft_reset_bit_r <= 1'b0;
    end else begin
      soft_reset_bit_r <= soft_reset_req;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_STANDBY;
      tmr_r <= '0;
      standby_prev_r <= STANDBY_PREV_RST;
    end else if (srst) begin
      st_r <= ST_STANDBY;
      tmr_r <= '0;
      standby_prev_r <= STANDBY_PREV_RST;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      standby_prev_r <= standby_bit;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      smp_cnt_r <= '0;
    end else if (srst || !ticking) begin
      smp_cnt_r <= '0;
    end else begin
      smp_cnt_r <= tick ? SAMPLE_LOAD : smp_cnt_r - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dac_r <= DAC_MID;
      dac_strobe_r <= 1'b0;
    end else if (srst || standby_bit) begin
      dac_r <= DAC_MID;
      dac_strobe_r <= 1'b0;
    end else begin
      if (pop) begin
        dac_r <= fifo_dout;
      end else if (ramp_step) begin
        dac_r <= dac_step;
      end
      dac_strobe_r <= pop | ramp_step;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ack_r <= 1'b0;
      wr_nak_r <= 1'b0;
      wr_dropped_r <= 1'b0;
      boost_en_r <= 1'b0;
      amp_en_r <= 1'b0;
      buf_full_r <= 1'b0;
      standby_active_r <= 1'b1;
      ramp_active_r <= 1'b0;
    end else if (srst) begin
      wr_ack_r <= 1'b0;
      wr_nak_r <= 1'b0;
      wr_dropped_r <= 1'b0;
      boost_en_r <= 1'b0;
      amp_en_r <= 1'b0;
      buf_full_r <= 1'b0;
      standby_active_r <= 1'b1;
      ramp_active_r <= 1'b0;
    end else begin
      wr_ack_r <= wr_take;
      wr_nak_r <= wr_refuse;
      wr_dropped_r <= drop;
      boost_en_r <= powered(st_nxt);
      amp_en_r <= powered(st_nxt);
      buf_full_r <= full_w;
      standby_active_r <= (st_nxt == ST_STANDBY);
      ramp_active_r <= (st_nxt == ST_RAMP);
    end
  end

  assign wr_ack = wr_ack_r;
  assign wr_nak = wr_nak_r;
  assign wr_dropped = wr_dropped_r;
  assign boost_en = boost_en_r;
  assign amp_en = amp_en_r;
  assign dac_code = dac_r;
  assign dac_strobe = dac_strobe_r;
  assign buf_full = buf_full_r;
  assign standby_active = standby_active_r;
  assign ramp_active = ramp_active_r;
  assign soft_reset_bit = soft_reset_bit_r;

  AST_NAK_WHEN_FULL: assert property (
    @(posedge ref_clk) disable iff (rst)
    wr_valid && full_w && !srst |=> wr_nak_r && !wr_ack_r)
    else $error("write to full buffer was not refused");

  AST_STANDBY_POWER_OFF: assert property (
    @(posedge ref_clk) disable iff (rst)
    standby_bit && !srst |=> !boost_en_r && !amp_en_r && st_r == ST_STANDBY)
    else $error("stages powered while standby held");

  AST_STANDBY_EXIT: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r == ST_STANDBY && standby_prev_r && !standby_bit && !srst |=> st_r == ST_IDLE)
    else $error("standby release did not ready the block");

  AST_WRITE_WAKES: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r == ST_IDLE && wr_valid && !full_w && !standby_bit && !srst
    |=> st_r == ST_WAKE && boost_en_r && amp_en_r)
    else $error("accepted write did not start wake-up");

  AST_FORCE_WAKES: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r == ST_IDLE && force_power_on_bit && !standby_bit && !srst |=> st_r == ST_WAKE)
    else $error("force-on did not start wake-up");

  AST_WAKE_COMPLETE: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r == ST_PLAY && $past(st_r) == ST_WAKE |-> $past(tmr_r) == '0 && boost_en_r)
    else $error("playback began before the wake interval ran out");

  AST_NO_SAMPLE_IN_WAKE: assert property (
    @(posedge ref_clk) disable iff (rst)
    dac_strobe_r |-> $past(st_r) == ST_PLAY || $past(st_r) == ST_HOLD
                     || $past(st_r) == ST_RAMP)
    else $error("converter updated outside playback");

  AST_SAMPLE_SPACING: assert property (
    @(posedge ref_clk) disable iff (rst)
    dac_strobe_r |=> !dac_strobe_r)
    else $error("converter updated on consecutive cycles");

  AST_RAMP_STEP: assert property (
    @(posedge ref_clk) disable iff (rst)
    ramp_step && !standby_bit && !srst
    |=> ($past(dac_r[7]) ? dac_r == $past(dac_r) + 8'h01 : dac_r == $past(dac_r) - 8'h01))
    else $error("ramp-down step wrong");

  AST_RAMP_DISCARD: assert property (
    @(posedge ref_clk) disable iff (rst)
    st_r == ST_RAMP && wr_valid && !full_w && !standby_bit && !srst
    |=> wr_dropped_r && wr_ack_r)
    else $error("write during ramp-down was not discarded");

  AST_SOFT_RESET: assert property (
    @(posedge ref_clk) disable iff (rst)
    soft_reset_bit_r && !soft_reset_req
    |=> st_r == ST_STANDBY && !soft_reset_bit_r && dac_r == DAC_MID && !boost_en_r)
    else $error("soft reset did not restore defaults");
endmodule

// *** rtl/sample_fifo.sv ***
// Sample buffer: first-in first-out store with flush
`timescale 1ns/1ps
module sample_fifo #(
  parameter int unsigned WIDTH = haptic_pkg::SAMPLE_W,
  parameter int unsigned DEPTH = haptic_pkg::BUF_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  output logic full,
  output logic empty
);
  import haptic_pkg::*;
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;

  assign full = (cnt_r == FULL_CNT);
  assign empty = (cnt_r == '0);
  assign dout = mem[rd_ptr_r];

  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= din;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule

// *** tb/haptic_playback_power_control_test.sv ***
// Self-checking bench for the haptic playback power control
`timescale 1ns/1ps
module haptic_playback_power_control_test;
  localparam int SC = 8;
  localparam int WC = 20;
  localparam int TC = 40;
  logic ref_clk, rst, wr_valid, standby_bit, force_power_on_bit, soft_reset_req;
  logic [7:0] wr_data, dac_code;
  logic wr_ack, wr_nak, wr_dropped, boost_en, amp_en, dac_strobe, buf_full;
  logic standby_active, ramp_active, soft_reset_bit;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  haptic_playback_power_control #(.SAMPLE_CYC(SC), .WAKE_CYC(WC), .TIMEOUT_CYC(TC),
    .BUF_DEPTH(4)) dut (.ref_clk(ref_clk), .rst(rst), .wr_valid(wr_valid),
    .wr_data(wr_data), .standby_bit(standby_bit), .force_power_on_bit(force_power_on_bit),
    .soft_reset_req(soft_reset_req), .wr_ack(wr_ack), .wr_nak(wr_nak),
    .wr_dropped(wr_dropped), .boost_en(boost_en), .amp_en(amp_en), .dac_code(dac_code),
    .dac_strobe(dac_strobe), .buf_full(buf_full), .standby_active(standby_active),
    .ramp_active(ramp_active), .soft_reset_bit(soft_reset_bit));
  host_writer host (.ref_clk(ref_clk), .wr_ack(wr_ack), .wr_nak(wr_nak),
    .wr_dropped(wr_dropped), .wr_valid(wr_valid), .wr_data(wr_data));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Counts falling edges until the chosen condition holds, up to a limit
  task automatic wait_for(input int sel, input int lim);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(negedge ref_clk);
      n++;
      case (sel)
        0: hit = (boost_en === 1'b1);
        1: hit = (dac_strobe === 1'b1);
        2: hit = (ramp_active === 1'b1);
        3: hit = (ramp_active === 1'b0);
        default: hit = (boost_en === 1'b0);
      endcase
    end
    chk("wait hit", {7'h00, hit}, 8'h01);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_play;
    host.send(8'h7f, 1'b0, 1);
    chk("ack", {7'h00, host.acked}, 8'h01);
    chk("boost", {7'h00, boost_en}, 8'h01);
    chk("amp", {7'h00, amp_en}, 8'h01);
    host.send(8'h80, 1'b0, 1);
    host.send(8'h00, 1'b0, 1);
    wait_for(1, WC + 10);
    chk("first strobe", 8'(n), 8'(WC - 3));
    chk("code", dac_code, 8'h7f);
    wait_for(1, SC + 2);
    chk("period", 8'(n), 8'(SC));
    chk("code", dac_code, 8'h80);
    wait_for(1, SC + 2);
    chk("code", dac_code, 8'h00);
    repeat (TC - 2) @(negedge ref_clk);
    chk("boost hold", {7'h00, boost_en}, 8'h01);
    wait_for(4, SC + 20);
    chk("no ramp", {7'h00, ramp_active}, 8'h00);
  endtask
  task automatic t_full_ramp;
    logic [7:0] seq [5] = '{8'h10, 8'h20, 8'h30, 8'h03, 8'h55};
    for (int i = 0; i < 4; i++) begin
      host.send(seq[i], 1'b0, 1);
    end
    host.send(8'h55, 1'b0, 1);
    chk("nak full", {7'h00, host.nakd}, 8'h01);
    chk("full", {7'h00, buf_full}, 8'h01);
    host.send(8'h55, 1'b1, 20);
    chk("resent", {7'h00, host.acked}, 8'h01);
    // First sample strobes while the resend is still in flight; its code holds until the next tick
    chk("fifo order", dac_code, seq[0]);
    for (int i = 1; i < 5; i++) begin
      wait_for(1, WC + SC);
      chk("fifo order", dac_code, seq[i]);
    end
    wait_for(2, TC + SC + 20);
    host.send(8'h11, 1'b0, 1);
    chk("dropped", {7'h00, host.dropped}, 8'h01);
    wait_for(3, 8'h55 * SC + 50);
    chk("ramp end", dac_code, 8'h00);
  endtask
  task automatic t_force_standby;
    repeat (TC + SC * 2) @(negedge ref_clk);
    force_power_on_bit = 1'b1;
    wait_for(0, 3);
    repeat (WC + 5) @(negedge ref_clk);
    host.send(8'h22, 1'b0, 1);
    wait_for(1, SC + 3);
    standby_bit = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("standby", {7'h00, standby_active}, 8'h01);
    chk("boost off", {7'h00, boost_en}, 8'h00);
    host.send(8'h33, 1'b0, 1);
    chk("nak standby", {7'h00, host.nakd}, 8'h01);
    standby_bit = 1'b0;
    force_power_on_bit = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("ready", {7'h00, standby_active}, 8'h00);
    host.send(8'h44, 1'b0, 1);
    chk("ack ready", {7'h00, host.acked}, 8'h01);
  endtask
  task automatic t_soft_reset;
    soft_reset_req = 1'b1;
    @(negedge ref_clk);
    soft_reset_req = 1'b0;
    chk("rst bit", {7'h00, soft_reset_bit}, 8'h01);
    @(negedge ref_clk);
    chk("rst bit clr", {7'h00, soft_reset_bit}, 8'h00);
    chk("rst standby", {7'h00, standby_active}, 8'h01);
    chk("rst boost", {7'h00, boost_en}, 8'h00);
    chk("rst code", dac_code, 8'h00);
  endtask
  initial begin
    rst = 1'b1;
    standby_bit = 1'b0;
    force_power_on_bit = 1'b0;
    soft_reset_req = 1'b0;
    repeat (10) @(negedge ref_clk);
    chk("reset standby", {7'h00, standby_active}, 8'h01);
    chk("reset code", dac_code, 8'h00);
    rst = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("idle", {7'h00, standby_active}, 8'h00);
    t_play();
    t_full_ramp();
    t_force_standby();
    t_soft_reset();
    wrap_up();
  end
  initial begin
    #200us;
    bad_count++;
    wrap_up();
  end
endmodule

// *** tb/host_writer.sv ***
// Host model that writes sample bytes to the entry register
`timescale 1ns/1ps
module host_writer (
  input wire logic ref_clk,
  input wire logic wr_ack,
  input wire logic wr_nak,
  input wire logic wr_dropped,
  output logic wr_valid,
  output logic [7:0] wr_data
);
  logic acked;
  logic nakd;
  logic dropped;
  initial begin
    wr_valid = 1'b0;
    wr_data = 8'h00;
  end
  // One byte per pulse; data lines show the inverse once released
  task automatic send(input logic [7:0] b, input logic retry, input int tries);
    for (int i = 0; i < tries; i++) begin
      @(negedge ref_clk);
      wr_valid = 1'b1;
      wr_data = b;
      @(negedge ref_clk);
      wr_valid = 1'b0;
      wr_data = ~b;
      acked = wr_ack;
      nakd = wr_nak;
      dropped = wr_dropped;
      if (nakd !== 1'b1 || !retry) break;
      // Refused byte is sent again after four more cycles when retry is set
      repeat (4) @(negedge ref_clk);
    end
  endtask
endmodule
